// [core/channel_clock_divider_ctrl.v]
/*
 * Channel clock dividers 1 and 2 with per-channel output routing,
 * power-down and duty-cycle-correction control, reached over APB.
 * Assumes CLK is the divider input clock; SYNC, OSC_CLK and EXT_CLK
 * are asynchronous pins; the source-select field lives here as well.
 */
`include "clkdiv_map.vh"

module channel_clock_divider_ctrl #(
	parameter ADDR_W = 12
) (
	input  wire              CLK,
	input  wire              RST_B,
	input  wire              PSEL,
	input  wire              PENABLE,
	input  wire              PWRITE,
	input  wire [ADDR_W-1:0] PADDR,
	input  wire [31:0]       PWDATA,
	output wire [31:0]       PRDATA,
	output wire              PREADY,
	output wire              PSLVERR,
	input  wire              SYNC,
	input  wire              OSC_CLK,
	input  wire              EXT_CLK,
	output wire              CH1_OUTPUT_A,
	output wire              CH1_OUTPUT_B,
	output wire              CH1_OUTPUT_C,
	output wire              CH2_OUTPUT_A,
	output wire              CH2_OUTPUT_B,
	output wire              CH2_OUTPUT_C,
	output wire              CH1_POWERED_DOWN,
	output wire              CH2_POWERED_DOWN,
	output wire              CH1_DUTY_CYCLE_CORRECTION,
	output wire              CH2_DUTY_CYCLE_CORRECTION
);

	localparam ST_HOLD  = 3'b001;
	localparam ST_DELAY = 3'b010;
	localparam ST_RUN   = 3'b100;

	// ****************************************
	// pin synchronisers
	// ****************************************
	// clocks are sampled as levels, so only tones well below CLK survive routing
	reg  [2:0]  pin_meta_reg;
	reg  [2:0]  pin_sync_reg;

	always @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			pin_meta_reg <= 3'h0;
			pin_sync_reg <= 3'h0;
		end else begin
			pin_meta_reg <= {EXT_CLK, OSC_CLK, SYNC};
			pin_sync_reg <= pin_meta_reg;
		end
	end

	wire        sync_s = pin_sync_reg[0];
	wire        osc_s  = pin_sync_reg[1];
	wire        ext_s  = pin_sync_reg[2];

	// ****************************************
	// apb slave
	// ****************************************
	reg         pready_reg;
	reg         pslverr_reg;
	reg  [31:0] prdata_reg;
	reg  [1:0]  src_sel_reg;
	reg  [31:0] rdata_next;
	reg         hit_next;

	wire [ADDR_W-3:0] widx     = PADDR[ADDR_W-1:2];
	wire              aligned  = (PADDR[1:0] == 2'h0);
	wire              access   = PSEL & PENABLE;
	// write lands only at the edge where the master sees pready high
	wire              wr_fire  = access & pready_reg & PWRITE & aligned;

	wire [15:0] period_all;
	wire [15:0] control_all;
	wire [5:0]  route_all;
	wire [7:0]  status_all;

	// unaligned addresses read zero and answer with an error
	always @* begin
		rdata_next = 32'h0;
		hit_next   = aligned;
		case (widx)
			`IDX_DIV1_PERIOD:     rdata_next = {24'h0, period_all[7:0]};
			`IDX_DIV1_CONTROL:    rdata_next = {24'h0, control_all[7:0]};
			`IDX_CH1_ROUTE_POWER: rdata_next = {29'h0, route_all[2:0]};
			`IDX_DIV2_PERIOD:     rdata_next = {24'h0, period_all[15:8]};
			`IDX_DIV2_CONTROL:    rdata_next = {24'h0, control_all[15:8]};
			`IDX_CH2_ROUTE_POWER: rdata_next = {29'h0, route_all[5:3]};
			`IDX_SOURCE_SELECT:   rdata_next = {30'h0, src_sel_reg};
			`IDX_DIV_STATUS:      rdata_next = {24'h0, status_all};
			default: begin
				hit_next = 1'b0;
			end
		endcase
		if (!aligned) begin
			rdata_next = 32'h0;
		end
	end

	// ****************************************
	// apb wait states
	// ****************************************
	// pready comes from a flop, so the count must be at least one
	reg  [3:0]  wait_cnt_reg;
	wire        wait_done = (wait_cnt_reg == (`APB_WAIT_STATES - 4'h1));

	always @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			wait_cnt_reg <= 4'h0;
		end else if (access & ~pready_reg & ~wait_done) begin
			wait_cnt_reg <= wait_cnt_reg + 4'h1;
		end else begin
			wait_cnt_reg <= 4'h0;
		end
	end

	// pready, error and read data stand for one cycle only
	always @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg  <= 32'h0;
		end else if (access & ~pready_reg & wait_done) begin
			pready_reg  <= 1'b1;
			pslverr_reg <= ~hit_next;
			prdata_reg  <= PWRITE ? 32'h0 : rdata_next;
		end else begin
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg  <= 32'h0;
		end
	end

	always @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			src_sel_reg <= `RST_SOURCE_SELECT;
		end else if (wr_fire && widx == `IDX_SOURCE_SELECT) begin
			src_sel_reg <= PWDATA[`SRC_SEL_HI:`SRC_SEL_LO];
		end
	end

	assign PREADY  = pready_reg;
	assign PSLVERR = pslverr_reg;
	assign PRDATA  = prdata_reg;

	// ****************************************
	// per-channel divider and routing
	// ****************************************
	wire [5:0] out_all;
	wire [1:0] pd_all;
	wire [1:0] dcc_all;

	genvar ch;
	generate
		for (ch = 0; ch < 2; ch = ch + 1) begin : chan
			localparam [ADDR_W-3:0] I_PER = (ch == 0) ? `IDX_DIV1_PERIOD : `IDX_DIV2_PERIOD;
			localparam [ADDR_W-3:0] I_CTL = (ch == 0) ? `IDX_DIV1_CONTROL : `IDX_DIV2_CONTROL;
			localparam [ADDR_W-3:0] I_RTE = (ch == 0) ? `IDX_CH1_ROUTE_POWER : `IDX_CH2_ROUTE_POWER;
			localparam [7:0]        R_PER = (ch == 0) ? `RST_DIV1_PERIOD : `RST_DIV2_PERIOD;

			reg  [7:0] period_reg;
			reg  [7:0] control_reg;
			reg  [2:0] route_reg;
			reg  [2:0] state_reg;
			reg  [2:0] state_next;
			reg  [3:0] cnt_reg;
			reg  [3:0] cnt_next;
			reg        level_reg;
			reg        level_next;
			reg        byp_tog_reg;
			reg  [2:0] out_reg;
			reg        pd_reg;
			reg        dcc_reg;
			reg        div_out;
			reg        out_next;

			wire       bypass   = control_reg[`CTL_BYPASS];
			wire       ign_sync = control_reg[`CTL_IGNORE_SYNC];
			wire       force_on = control_reg[`CTL_FORCE];
			wire       start_hi = control_reg[`CTL_START_HIGH];
			wire [3:0] phase    = control_reg[`CTL_PHASE_HI:`CTL_PHASE_LO];
			wire [3:0] low_cnt  = period_reg[`PER_LOW_HI:`PER_LOW_LO];
			wire [3:0] high_cnt = period_reg[`PER_HIGH_HI:`PER_HIGH_LO];
			wire       pd       = route_reg[`RTE_POWER_DOWN];
			wire       direct   = route_reg[`RTE_DIRECT];
			wire       sync_hit = sync_s & ~ign_sync;

			always @(posedge CLK or negedge RST_B) begin
				if (!RST_B) begin
					period_reg  <= R_PER;
					control_reg <= `RST_CONTROL;
					route_reg   <= `RST_ROUTE_POWER;
				end else if (wr_fire) begin
					if (widx == I_PER) begin
						period_reg <= PWDATA[7:0];
					end
					if (widx == I_CTL) begin
						control_reg <= PWDATA[7:0];
					end
					if (widx == I_RTE) begin
						route_reg <= PWDATA[2:0];
					end
				end
			end

			always @* begin
				state_next = state_reg;
				cnt_next   = cnt_reg;
				level_next = level_reg;
				if (sync_hit) begin
					// held while sync stands, counter cleared
					state_next = ST_HOLD;
					cnt_next   = 4'h0;
					level_next = start_hi;
				end else begin
					case (state_reg)
						ST_HOLD: begin
							state_next = ST_DELAY;
							cnt_next   = 4'h0;
						end
						ST_DELAY: begin
							if (cnt_reg >= phase) begin
								state_next = ST_RUN;
								cnt_next   = 4'h0;
								level_next = start_hi;
							end else begin
								cnt_next = cnt_reg + 4'h1;
							end
						end
						ST_RUN: begin
							// >= so a count lowered mid-level ends it at once instead of wrapping
							if (cnt_reg >= (level_reg ? high_cnt : low_cnt)) begin
								level_next = ~level_reg;
								cnt_next   = 4'h0;
							end else begin
								cnt_next = cnt_reg + 4'h1;
							end
						end
						default: begin
							state_next = ST_HOLD;
							cnt_next   = 4'h0;
						end
					endcase
				end
			end

			always @* begin
				if (bypass) begin
					// toggling at input rate; force deliberately ignored here
					div_out = byp_tog_reg;
				end else if (ign_sync & force_on) begin
					// forcing needs ignore-sync too, so a sync never fights a forced level
					div_out = start_hi;
				end else begin
					div_out = level_reg;
				end
				// power-down wins over routing, so a dead channel never leaks a clock
				if (pd) begin
					out_next = 1'b0;
				end else if (direct && src_sel_reg == `SRC_OSCILLATOR) begin
					out_next = osc_s;
				end else if (direct && src_sel_reg == `SRC_EXT_CLOCK) begin
					out_next = ext_s;
				end else begin
					// 01b and the unlisted 11b leave the divider connected
					out_next = div_out;
				end
			end

			always @(posedge CLK or negedge RST_B) begin
				if (!RST_B) begin
					state_reg   <= ST_DELAY;
					cnt_reg     <= 4'h0;
					level_reg   <= 1'b0;
					byp_tog_reg <= 1'b0;
					out_reg     <= 3'h0;
					pd_reg      <= 1'b0;
					dcc_reg     <= 1'b0;
				end else begin
					// counter frozen while bypassed; divider is held but not flagged as powered down
					if (!bypass) begin
						state_reg <= state_next;
						cnt_reg   <= cnt_next;
						level_reg <= level_next;
					end
					// cleared outside bypass, so bypass always starts from a low level
					byp_tog_reg <= bypass ? ~byp_tog_reg : 1'b0;
					out_reg     <= {3{out_next}};
					pd_reg      <= pd;
					dcc_reg     <= ~route_reg[`RTE_DCC_DISABLE];
				end
			end

			assign period_all[ch*8 +: 8]  = period_reg;
			assign control_all[ch*8 +: 8] = control_reg;
			assign route_all[ch*3 +: 3]   = route_reg;
			// status is read-only; a write to it lands nowhere and raises no error
			assign status_all[ch*4 +: 4]  = {level_reg, state_reg};
			assign out_all[ch*3 +: 3]     = out_reg;
			assign pd_all[ch]             = pd_reg;
			assign dcc_all[ch]            = dcc_reg;
		end
	endgenerate

	// ****************************************
	// outputs
	// ****************************************
	// a channel's three pins load one next value, so they never skew
	assign CH1_OUTPUT_A              = out_all[0];
	assign CH1_OUTPUT_B              = out_all[1];
	assign CH1_OUTPUT_C              = out_all[2];
	assign CH2_OUTPUT_A              = out_all[3];
	assign CH2_OUTPUT_B              = out_all[4];
	assign CH2_OUTPUT_C              = out_all[5];
	assign CH1_POWERED_DOWN          = pd_all[0];
	assign CH2_POWERED_DOWN          = pd_all[1];
	assign CH1_DUTY_CYCLE_CORRECTION = dcc_all[0];
	assign CH2_DUTY_CYCLE_CORRECTION = dcc_all[1];

endmodule // channel_clock_divider_ctrl

// [core/clkdiv_map.vh]
/*
 * Register map, field positions, reset values and timing counts of the
 * channel clock divider control block.
 * Assumes inclusion by bare name from the block's design file.
 */
`ifndef CLKDIV_MAP_VH
`define CLKDIV_MAP_VH

// ****************************************
// register indices (byte address = index * 4)
// ****************************************
`define IDX_DIV1_PERIOD      10'h193
`define IDX_DIV1_CONTROL     10'h194
`define IDX_CH1_ROUTE_POWER  10'h195
`define IDX_DIV2_PERIOD      10'h196
`define IDX_DIV2_CONTROL     10'h197
`define IDX_CH2_ROUTE_POWER  10'h198
`define IDX_SOURCE_SELECT    10'h1E1
`define IDX_DIV_STATUS       10'h1F0

// ****************************************
// field positions
// ****************************************
`define PER_LOW_HI           7
`define PER_LOW_LO           4
`define PER_HIGH_HI          3
`define PER_HIGH_LO          0
`define CTL_BYPASS           7
`define CTL_IGNORE_SYNC      6
`define CTL_FORCE            5
`define CTL_START_HIGH       4
`define CTL_PHASE_HI         3
`define CTL_PHASE_LO         0
`define RTE_POWER_DOWN       2
`define RTE_DIRECT           1
`define RTE_DCC_DISABLE      0
`define SRC_SEL_HI           1
`define SRC_SEL_LO           0

// ****************************************
// reset values and encodings
// ****************************************
`define RST_DIV1_PERIOD      8'h33
`define RST_DIV2_PERIOD      8'h11
`define RST_CONTROL          8'h00
`define RST_ROUTE_POWER      3'h0
`define RST_SOURCE_SELECT    2'h1
`define SRC_EXT_CLOCK        2'h0
`define SRC_NO_DIRECT        2'h1
`define SRC_OSCILLATOR       2'h2

// ****************************************
// timing counts
// ****************************************
`define APB_WAIT_STATES      4'h1

`endif

// [sim/clkdiv_sva.sv]
/*
 * Checker of the bus handshake and of the channel output relations.
 * Assumes binding to the ports of the divider block's top module.
 */
module clkdiv_sva (
	input logic        CLK,
	input logic        RST_B,
	input logic        PSEL,
	input logic        PENABLE,
	input logic        PREADY,
	input logic        PSLVERR,
	input logic [31:0] PRDATA,
	input logic        CH1_OUTPUT_A,
	input logic        CH1_OUTPUT_B,
	input logic        CH1_OUTPUT_C,
	input logic        CH2_OUTPUT_A,
	input logic        CH2_OUTPUT_B,
	input logic        CH2_OUTPUT_C,
	input logic        CH1_POWERED_DOWN,
	input logic        CH2_POWERED_DOWN
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_B);
	// ******
	// bus answer
	// ******
	a_ready_latency: assert property (PSEL && !PENABLE |=> !PREADY ##1 PREADY) else $error("ready late");
	a_ready_pulse: assert property (PREADY |=> !PREADY) else $error("ready too long");
	a_err_ready: assert property (PSLVERR |-> PREADY) else $error("error without ready");
	a_rdata_idle: assert property (!PREADY |-> PRDATA == 32'h0) else $error("read data outside answer");
	// ******
	// channel outputs
	// ******
	a_ch1_equal: assert property (CH1_OUTPUT_A == CH1_OUTPUT_B && CH1_OUTPUT_B == CH1_OUTPUT_C)
		else $error("channel 1 outputs differ");
	a_ch2_equal: assert property (CH2_OUTPUT_A == CH2_OUTPUT_B && CH2_OUTPUT_B == CH2_OUTPUT_C)
		else $error("channel 2 outputs differ");
	// the output flop clears on the same edge that raises the flag; the check waits three cycles of power-down
	a_ch1_pd_low: assert property (CH1_POWERED_DOWN [*3] |-> !CH1_OUTPUT_A)
		else $error("channel 1 output live in power-down");
	a_ch2_pd_low: assert property (CH2_POWERED_DOWN [*3] |-> !CH2_OUTPUT_A)
		else $error("channel 2 output live in power-down");
endmodule // clkdiv_sva

// [sim/clk_consumer.sv]
/*
 * Downstream clock consumer: measures high and low run lengths of a line.
 * Assumes the line is sampled on the block's own clock.
 */
module clk_consumer (
	input  logic clk,
	input  logic rst_b,
	input  logic line,
	output int   last_high,
	output int   last_low
);
	timeunit 1ns;
	timeprecision 1ns;
	logic prev;
	int   run;
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			prev <= 1'b0;
			run <= 0;
			last_high <= 0;
			last_low <= 0;
		end else if (line !== prev) begin
			if (prev)
				last_high <= run;
			else
				last_low <= run;
			prev <= line;
			run <= 1;
		end else begin
			run <= run + 1;
		end
	end
endmodule // clk_consumer

// [sim/tb_channel_clock_divider_ctrl.sv]
/*
 * Self-checking bench of the channel clock divider block.
 * Assumes the block's map header and the clock consumer model.
 */
`include "clkdiv_map.vh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_fail++; \
	$display("ERROR %0t got %h exp %h", $time, a, b); end end
module tb_channel_clock_divider_ctrl;
	timeunit 1ns;
	timeprecision 1ns;
	logic        CLK, RST_B, PSEL, PENABLE, PWRITE, SYNC, OSC_CLK, EXT_CLK;
	logic [11:0] PADDR;
	logic [31:0] PWDATA;
	wire  [31:0] PRDATA;
	wire         PREADY, PSLVERR, CH1_OUTPUT_A, CH1_OUTPUT_B, CH1_OUTPUT_C, CH2_OUTPUT_A, CH2_OUTPUT_B;
	wire         CH2_OUTPUT_C, CH1_POWERED_DOWN, CH2_POWERED_DOWN;
	wire         CH1_DUTY_CYCLE_CORRECTION, CH2_DUTY_CYCLE_CORRECTION;
	int          n_fail, n_tests, hi1, lo1, hi2, lo2, g0, g3, gl, ec, oc;
	channel_clock_divider_ctrl i_dut (.CLK, .RST_B, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
		.PREADY, .PSLVERR, .SYNC, .OSC_CLK, .EXT_CLK, .CH1_OUTPUT_A, .CH1_OUTPUT_B, .CH1_OUTPUT_C,
		.CH2_OUTPUT_A, .CH2_OUTPUT_B, .CH2_OUTPUT_C, .CH1_POWERED_DOWN, .CH2_POWERED_DOWN,
		.CH1_DUTY_CYCLE_CORRECTION, .CH2_DUTY_CYCLE_CORRECTION);
	clk_consumer i_c1 (.clk(CLK), .rst_b(RST_B), .line(CH1_OUTPUT_A), .last_high(hi1), .last_low(lo1));
	clk_consumer i_c2 (.clk(CLK), .rst_b(RST_B), .line(CH2_OUTPUT_A), .last_high(hi2), .last_low(lo2));
	// ******
	// clocks
	// ******
	initial begin
		CLK = 1'b0;
		forever #25 CLK = ~CLK;
	end
	// distinct rates so each routed source shows its own run lengths
	always @(posedge CLK) begin
		ec <= (ec == 9) ? 0 : ec + 1;
		oc <= (oc == 5) ? 0 : oc + 1;
		EXT_CLK <= (ec < 5);
		OSC_CLK <= (oc < 3);
	end
	// ******
	// helpers
	// ******
	function automatic logic [11:0] ad(input logic [9:0] i);
		return {i, 2'b00};
	endfunction
	task automatic tally_and_finish;
		if (n_fail == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int i;
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLK);
		PENABLE <= 1'b1;
		i = 0;
		do begin
			@(posedge CLK);
			i++;
		end while (PREADY !== 1'b1 && i < 20);
		r = PRDATA;
		e = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		@(posedge CLK);
		if (i >= 20) begin
			n_fail++;
			tally_and_finish();
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 32'h0, r, e);
		`CHK(r, x)
		`CHK(e, xe)
	endtask
	task automatic chg(input int n, output int c);
		logic p;
		c = 0;
		p = CH1_OUTPUT_A;
		repeat (n) begin
			@(posedge CLK);
			if (CH1_OUTPUT_A !== p)
				c++;
			p = CH1_OUTPUT_A;
		end
	endtask
	// latency of the synchroniser cancels when two gaps are subtracted
	task automatic sync_gap(input logic [7:0] c, output int n);
		wr(ad(`IDX_DIV1_CONTROL), c);
		SYNC <= 1'b1;
		repeat (8) @(posedge CLK);
		`CHK(CH1_OUTPUT_A, c[4])
		SYNC <= 1'b0;
		n = 0;
		while (CH1_OUTPUT_A === c[4] && n < 60) begin
			@(posedge CLK);
			n++;
		end
		if (n >= 60) begin
			n_fail++;
			tally_and_finish();
		end
	endtask
	// ******
	// scenarios
	// ******
	task automatic t_reset;
		rd(ad(`IDX_DIV1_PERIOD), `RST_DIV1_PERIOD, 1'b0);
		`CHK({CH1_DUTY_CYCLE_CORRECTION, CH2_DUTY_CYCLE_CORRECTION}, 2'b11)
		rd(ad(`IDX_DIV2_PERIOD), `RST_DIV2_PERIOD, 1'b0);
		rd(ad(`IDX_DIV1_CONTROL), `RST_CONTROL, 1'b0);
		rd(ad(`IDX_CH1_ROUTE_POWER), `RST_ROUTE_POWER, 1'b0);
		rd(ad(`IDX_SOURCE_SELECT), `RST_SOURCE_SELECT, 1'b0);
		rd(12'h004, 32'h0, 1'b1);
		`CHK(hi2, 2)
		`CHK(lo2, 2)
	endtask
	task automatic t_counts;
		wr(ad(`IDX_DIV1_PERIOD), 32'h72);
		repeat (30) @(posedge CLK);
		`CHK(lo1, 8)
		`CHK(hi1, 3)
	endtask
	task automatic t_sync;
		sync_gap(8'h10, g0);
		sync_gap(8'h13, g3);
		sync_gap(8'h00, gl);
		`CHK(g3 - g0, 3)
		`CHK(gl - g0, 5)
		wr(ad(`IDX_DIV1_CONTROL), 32'h40);
		SYNC <= 1'b1;
		chg(30, g0);
		SYNC <= 1'b0;
		`CHK(g0 >= 4, 1'b1)
	endtask
	task automatic t_force;
		for (int k = 0; k < 2; k++) begin
			wr(ad(`IDX_DIV1_CONTROL), k ? 32'h60 : 32'h70);
			repeat (4) @(posedge CLK);
			`CHK(CH1_OUTPUT_A, k ? 1'b0 : 1'b1)
			chg(12, g0);
			`CHK(g0, 0)
		end
		wr(ad(`IDX_DIV1_CONTROL), 32'h30);
		chg(30, g0);
		`CHK(g0 >= 4, 1'b1)
	endtask
	task automatic t_bypass;
		wr(ad(`IDX_DIV1_CONTROL), 32'hF0);
		repeat (10) @(posedge CLK);
		`CHK(hi1, 1)
		`CHK(lo1, 1)
		wr(ad(`IDX_DIV1_CONTROL), 32'h0);
	endtask
	task automatic t_route;
		logic [1:0] s [3] = '{`SRC_EXT_CLOCK, `SRC_OSCILLATOR, `SRC_NO_DIRECT};
		int         h [3] = '{5, 3, 3};
		int         l [3] = '{5, 3, 8};
		wr(ad(`IDX_CH1_ROUTE_POWER), 32'h2);
		for (int k = 0; k < 3; k++) begin
			wr(ad(`IDX_SOURCE_SELECT), {30'h0, s[k]});
			repeat (40) @(posedge CLK);
			`CHK(hi1, h[k])
			`CHK(lo1, l[k])
		end
		wr(ad(`IDX_SOURCE_SELECT), 32'h0);
		wr(ad(`IDX_CH1_ROUTE_POWER), 32'h0);
		repeat (40) @(posedge CLK);
		`CHK(lo1, 8)
	endtask
	task automatic t_power;
		wr(ad(`IDX_CH1_ROUTE_POWER), 32'h5);
		wr(ad(`IDX_CH2_ROUTE_POWER), 32'h4);
		repeat (2) @(posedge CLK);
		`CHK({CH1_POWERED_DOWN, CH2_POWERED_DOWN}, 2'b11)
		`CHK({CH1_DUTY_CYCLE_CORRECTION, CH2_DUTY_CYCLE_CORRECTION}, 2'b01)
		chg(12, g0);
		`CHK({g0 == 0, CH1_OUTPUT_A, CH2_OUTPUT_A}, 3'b100)
		wr(ad(`IDX_CH1_ROUTE_POWER), 32'h0);
		chg(30, g0);
		`CHK(g0 >= 4, 1'b1)
	endtask
	// ******
	// main sequence
	// ******
	initial begin
		RST_B = 1'b0;
		PSEL = 1'b0;
		PENABLE = 1'b0;
		PWRITE = 1'b0;
		PADDR = 12'h0;
		PWDATA = 32'h0;
		SYNC = 1'b0;
		repeat (4) @(posedge CLK);
		RST_B <= 1'b1;
		@(posedge CLK);
		t_reset();
		t_counts();
		t_sync();
		t_force();
		t_bypass();
		t_route();
		t_power();
		tally_and_finish();
	end
endmodule // tb_channel_clock_divider_ctrl
bind channel_clock_divider_ctrl clkdiv_sva i_sva (.CLK, .RST_B, .PSEL, .PENABLE, .PREADY, .PSLVERR, .PRDATA,
	.CH1_OUTPUT_A, .CH1_OUTPUT_B, .CH1_OUTPUT_C, .CH2_OUTPUT_A, .CH2_OUTPUT_B, .CH2_OUTPUT_C,
	.CH1_POWERED_DOWN, .CH2_POWERED_DOWN);
